// file: shared/die_temp_cfg.svh
`ifndef DIE_TEMP_CFG_SVH
`define DIE_TEMP_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_REF_TEMP_CTRL   12'h20C
`define OFS_TEMP_RESULT     12'h210
`define OFS_TEMP_STATUS     12'h214
`define OFS_TEMP_CLEAR      12'h218
`define OFS_TEMP_ENABLE     12'h21C

// ----------------------------------------
// Control field positions and reset value
// ----------------------------------------
`define BIT_REF_ENABLE      7
`define BIT_REF_READY       6
`define BIT_SENSOR_ENABLE   5
`define BIT_RANGE_SELECT    4
`define CTRL_RESET          8'h00

// ----------------------------------------
// Event bits
// ----------------------------------------
`define EVT_CONV_DONE       0
`define EVT_REF_READY       1

// ----------------------------------------
// Conversion constants
// ----------------------------------------
`define GAIN_SHIFT          8
`define TEMP_DIVISOR        25'sd10
`define DIV_STEPS           5'd25

`endif

// file: shared/die_temp_pkg.sv
package die_temp_pkg;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic       ref_enable;
      logic       sensor_enable;
      logic       sensor_range_select;
      logic [1:0] second_buffer_gain;
      logic [1:0] first_buffer_gain;
   } ctrl_type;

   typedef struct packed {
      logic [15:0] low_range_gain_const;
      logic [15:0] high_range_gain_const;
      logic [15:0] low_range_offset_const;
      logic [15:0] high_range_offset_const;
   } calib_type;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SCALE  = 3'b010,
      ST_DIVIDE = 3'b100
   } conv_state_type;

endpackage : die_temp_pkg

// file: hw/die_temp_indicator_ctrl.sv
// The strobed register port is this design's own decision.
`include "die_temp_cfg.svh"

module die_temp_indicator_ctrl (
   // Clock, reset, enable
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  clk_en,
   // Register port
   input  wire logic [11:0]           reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_write,
   input  wire logic                  reg_read,
   output logic      [7:0]            reg_rdata,
   // Analog side
   input  wire logic                  ref_settled,
   output die_temp_pkg::ctrl_type     analog_ctrl,
   output logic                       buf2_to_dac_cmp,
   output logic                       buf2_to_adc_channel,
   output logic                       buf1_to_adc_reference,
   output logic                       buf1_to_adc_channel,
   // ADC count and calibration
   input  wire logic                  count_valid,
   input  wire logic [15:0]           sensor_adc_count,
   input  wire die_temp_pkg::calib_type calib,
   // Result and interrupt
   output logic signed [15:0]         temp_celsius,
   output logic                       temp_valid,
   output logic                       irq
);

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   die_temp_pkg::ctrl_type ctrl_ff, nxt_ctrl;
   logic                   ready_flag;
   logic                   sel_ctrl;

   assign sel_ctrl = (reg_addr == `OFS_REF_TEMP_CTRL);

   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (reg_write && sel_ctrl) begin
         nxt_ctrl.ref_enable          = reg_wdata[`BIT_REF_ENABLE];
         nxt_ctrl.sensor_enable       = reg_wdata[`BIT_SENSOR_ENABLE];
         nxt_ctrl.sensor_range_select = reg_wdata[`BIT_RANGE_SELECT];
         nxt_ctrl.second_buffer_gain  = reg_wdata[3:2];
         nxt_ctrl.first_buffer_gain   = reg_wdata[1:0];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= die_temp_pkg::ctrl_type'(7'(`CTRL_RESET));
      end else if (clk_en) begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   assign ready_flag  = ctrl_ff.ref_enable & ref_settled;
   assign analog_ctrl = ctrl_ff;

   ref_buffer_route second_route (
      .ref_enable     (ctrl_ff.ref_enable),
      .gain           (ctrl_ff.second_buffer_gain),
      .to_first_sink  (buf2_to_dac_cmp),
      .to_second_sink (buf2_to_adc_channel)
   );

   ref_buffer_route first_route (
      .ref_enable     (ctrl_ff.ref_enable),
      .gain           (ctrl_ff.first_buffer_gain),
      .to_first_sink  (buf1_to_adc_reference),
      .to_second_sink (buf1_to_adc_channel)
   );

   // ----------------------------------------
   // Conversion
   // ----------------------------------------
   die_temp_pkg::conv_state_type state_ff, nxt_state;
   logic [15:0]         count_ff, nxt_count;
   logic [24:0]         quot_ff, nxt_quot;
   logic [24:0]         rem_ff, nxt_rem;
   logic                neg_ff, nxt_neg;
   logic [4:0]          step_ff, nxt_step;
   logic signed [15:0]  temp_ff, nxt_temp;
   logic                done_ff, nxt_done;
   logic [15:0]         gain_sel;
   logic signed [15:0]  offset_sel;
   logic [31:0]         product;
   logic signed [24:0]  scaled;
   logic [24:0]         rem_shift;

   assign gain_sel   = ctrl_ff.sensor_range_select ? calib.high_range_gain_const
                                                   : calib.low_range_gain_const;
   assign offset_sel = ctrl_ff.sensor_range_select ? calib.high_range_offset_const
                                                   : calib.low_range_offset_const;
   assign product    = count_ff * gain_sel;
   assign scaled     = $signed({1'b0, product[31:`GAIN_SHIFT]}) + 25'(offset_sel);
   assign rem_shift  = {rem_ff[23:0], quot_ff[24]};

   always_comb begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      nxt_quot  = quot_ff;
      nxt_rem   = rem_ff;
      nxt_neg   = neg_ff;
      nxt_step  = step_ff;
      nxt_temp  = temp_ff;
      nxt_done  = 1'b0;
      unique case (state_ff)
         die_temp_pkg::ST_IDLE: begin
            // A count taken while the sensor is off is meaningless, so it is dropped.
            if (count_valid && ctrl_ff.sensor_enable) begin
               nxt_count = sensor_adc_count;
               nxt_state = die_temp_pkg::ST_SCALE;
            end
         end
         die_temp_pkg::ST_SCALE: begin
            nxt_neg   = scaled[24];
            nxt_quot  = scaled[24] ? 25'(-scaled) : 25'(scaled);
            nxt_rem   = 25'h0;
            nxt_step  = 5'h0;
            nxt_state = die_temp_pkg::ST_DIVIDE;
         end
         die_temp_pkg::ST_DIVIDE: begin
            // divide by ten
            // Restoring division, one bit per cycle, truncating toward zero as
            // the integer form of the equation does; trades latency for area.
            if (rem_shift >= 25'(`TEMP_DIVISOR)) begin
               nxt_rem  = rem_shift - 25'(`TEMP_DIVISOR);
               nxt_quot = {quot_ff[23:0], 1'b1};
            end else begin
               nxt_rem  = rem_shift;
               nxt_quot = {quot_ff[23:0], 1'b0};
            end
            nxt_step = step_ff + 5'h1;
            if (step_ff == `DIV_STEPS - 5'h1) begin
               nxt_temp  = neg_ff ? -$signed(nxt_quot[15:0]) : $signed(nxt_quot[15:0]);
               nxt_done  = 1'b1;
               nxt_state = die_temp_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = die_temp_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= die_temp_pkg::ST_IDLE;
         count_ff <= 16'h0000;
         quot_ff  <= 25'h0;
         rem_ff   <= 25'h0;
         neg_ff   <= 1'b0;
         step_ff  <= 5'h0;
         temp_ff  <= 16'sh0000;
         done_ff  <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         count_ff <= nxt_count;
         quot_ff  <= nxt_quot;
         rem_ff   <= nxt_rem;
         neg_ff   <= nxt_neg;
         step_ff  <= nxt_step;
         temp_ff  <= nxt_temp;
         done_ff  <= nxt_done;
      end
   end

   assign temp_celsius = temp_ff;
   assign temp_valid   = done_ff;

   // ----------------------------------------
   // Events and interrupt
   // ----------------------------------------
   logic [1:0] status_ff, nxt_status;
   logic [1:0] irq_en_ff, nxt_irq_en;
   logic       ready_ff;
   logic [1:0] events;

   assign events = {ready_flag & ~ready_ff, done_ff};

   always_comb begin
      nxt_status = status_ff;
      nxt_irq_en = irq_en_ff;
      if (reg_write && (reg_addr == `OFS_TEMP_CLEAR)) begin
         nxt_status = status_ff & ~reg_wdata[1:0];
      end
      if (reg_write && (reg_addr == `OFS_TEMP_ENABLE)) begin
         nxt_irq_en = reg_wdata[1:0];
      end
      // A new event wins over a clear in the same cycle.
      nxt_status = nxt_status | events;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status_ff <= 2'h0;
         irq_en_ff <= 2'h0;
         ready_ff  <= 1'b0;
      end else if (clk_en) begin
         status_ff <= nxt_status;
         irq_en_ff <= nxt_irq_en;
         ready_ff  <= ready_flag;
      end
   end

   assign irq = |(status_ff & irq_en_ff);

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   logic [7:0] rdata_ff, nxt_rdata;

   always_comb begin
      nxt_rdata = rdata_ff;
      if (reg_read) begin
         unique case (reg_addr)
            `OFS_REF_TEMP_CTRL: nxt_rdata = {ctrl_ff.ref_enable, ready_flag,
                                             ctrl_ff.sensor_enable,
                                             ctrl_ff.sensor_range_select,
                                             ctrl_ff.second_buffer_gain,
                                             ctrl_ff.first_buffer_gain};
            `OFS_TEMP_RESULT:   nxt_rdata = temp_ff[7:0];
            `OFS_TEMP_STATUS:   nxt_rdata = {6'h00, status_ff};
            `OFS_TEMP_ENABLE:   nxt_rdata = {6'h00, irq_en_ff};
            default:            nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (clk_en) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule : die_temp_indicator_ctrl

// ----------------------------------------
// Reference buffer routing
// ----------------------------------------
module ref_buffer_route (
   // Control
   input  wire logic       ref_enable,
   input  wire logic [1:0] gain,
   // Routing
   output logic            to_first_sink,
   output logic            to_second_sink
);

   // A buffer routes only while the reference runs and its gain is nonzero, so an
   // off buffer never presents a floating level to a consumer.
   assign to_first_sink  = ref_enable && (gain != 2'h0);
   assign to_second_sink = to_first_sink;

endmodule : ref_buffer_route

// file: tb/die_temp_indicator_ctrl_props.sv
`include "die_temp_cfg.svh"

module die_temp_indicator_ctrl_props (
   // Clock and register port
   input wire logic                   ref_clk,
   input wire logic                   rst,
   input wire logic                   clk_en,
   input wire logic [11:0]            reg_addr,
   input wire logic [7:0]             reg_wdata,
   input wire logic                   reg_write,
   input wire logic                   reg_read,
   input wire logic [7:0]             reg_rdata,
   // Analog side and result
   input wire logic                   ref_settled,
   input wire die_temp_pkg::ctrl_type analog_ctrl,
   input wire logic                   buf2_to_dac_cmp,
   input wire logic                   buf2_to_adc_channel,
   input wire logic                   buf1_to_adc_reference,
   input wire logic                   buf1_to_adc_channel,
   input wire logic                   count_valid,
   input wire logic                   temp_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       wr_ctl;
   logic       rd_ctl;
   logic       rdy_live;
   logic [6:0] wr_img;
   logic [7:0] ctl_img;
   assign wr_ctl = clk_en && reg_write && reg_addr == `OFS_REF_TEMP_CTRL;
   assign rd_ctl = clk_en && reg_read && reg_addr == `OFS_REF_TEMP_CTRL;
   assign rdy_live = analog_ctrl.ref_enable && ref_settled;
   // The ready bit is not storage, so the written image skips it.
   assign wr_img = {reg_wdata[7], reg_wdata[5:0]};
   assign ctl_img = {analog_ctrl[6], rdy_live, analog_ctrl[5:0]};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_ctrl_write: assert property (wr_ctl |=> analog_ctrl == $past(wr_img))
      else $error("control fields differ from write");
   a_ctrl_hold: assert property (!wr_ctl |=> $stable(analog_ctrl))
      else $error("control changed without a write");
   a_ctrl_read: assert property (rd_ctl |=> reg_rdata == $past(ctl_img))
      else $error("control read image wrong");
   a_ready_low: assert property (rd_ctl && !rdy_live |=> !reg_rdata[6])
      else $error("ready read high while not ready");
   a_buf2_route: assert property (buf2_to_dac_cmp == (analog_ctrl.ref_enable
      && analog_ctrl.second_buffer_gain != 2'h0) && buf2_to_adc_channel == buf2_to_dac_cmp)
      else $error("second buffer routing wrong");
   a_buf1_route: assert property (buf1_to_adc_reference == (analog_ctrl.ref_enable
      && analog_ctrl.first_buffer_gain != 2'h0) && buf1_to_adc_channel == buf1_to_adc_reference)
      else $error("first buffer routing wrong");
   a_reset_clear: assert property ($fell(rst) |-> analog_ctrl == 7'h00)
      else $error("control not cleared by reset");
   a_conv_latency: assert property (temp_valid |-> $past(count_valid, 27))
      else $error("result without count 27 cycles before");
   a_valid_pulse: assert property (temp_valid |=> !temp_valid)
      else $error("result strobe longer than one cycle");
endmodule : die_temp_indicator_ctrl_props

bind die_temp_indicator_ctrl die_temp_indicator_ctrl_props props (.ref_clk, .rst, .clk_en,
   .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .ref_settled, .analog_ctrl,
   .buf2_to_dac_cmp, .buf2_to_adc_channel, .buf1_to_adc_reference, .buf1_to_adc_channel,
   .count_valid, .temp_valid);

// file: tb/die_temp_adc_model.sv
module die_temp_adc_model #(
   parameter die_temp_pkg::calib_type CAL        = '0,
   parameter int                      ACQ_CYCLES = 4,
   parameter int                      SETTLE     = 3
) (
   // Clock and control
   input  wire logic                    ref_clk,
   input  wire die_temp_pkg::ctrl_type  analog_ctrl,
   // Reference, count and constants
   output logic                         ref_settled,
   output logic                         count_valid,
   output logic [15:0]                  sensor_adc_count,
   output die_temp_pkg::calib_type      calib
);
   timeunit 1ns;
   timeprecision 100ps;
   int settle_cnt = 0;
   initial count_valid = 1'b0;
   initial sensor_adc_count = 16'h5A5A;
   assign calib = CAL;
   // The reference needs a few cycles after enable before it is usable.
   always @(posedge ref_clk) settle_cnt <= analog_ctrl.ref_enable ? settle_cnt + 1 : 0;
   assign ref_settled = settle_cnt >= SETTLE;
   task automatic send_count(input logic [15:0] c);
      repeat (ACQ_CYCLES) @(posedge ref_clk);
      count_valid <= 1'b1;
      sensor_adc_count <= c;
      @(posedge ref_clk);
      count_valid <= 1'b0;
      // Stale data is inverted so a late sample cannot pass by luck.
      sensor_adc_count <= ~c;
   endtask : send_count
endmodule : die_temp_adc_model

// file: tb/test_die_temp_indicator_ctrl.sv
`include "die_temp_cfg.svh"

module test_die_temp_indicator_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   localparam die_temp_pkg::calib_type CAL = '{16'h0A40, 16'h0C00, 16'hFC18, 16'h0190};
   logic                    ref_clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    clk_en = 1'b1;
   logic [11:0]             reg_addr = 12'h000;
   logic [7:0]              reg_wdata = 8'h00;
   logic                    reg_write = 1'b0;
   logic                    reg_read = 1'b0;
   logic [7:0]              reg_rdata;
   logic                    ref_settled, count_valid, temp_valid, irq, b2d, b2a, b1r, b1c;
   logic [15:0]             sensor_adc_count;
   logic signed [15:0]      temp_celsius;
   die_temp_pkg::ctrl_type  analog_ctrl;
   die_temp_pkg::calib_type calib;
   int                      bad_count = 0, total_checks = 0, n_valid = 0, n_old, avg_sum;
   logic [16:0]             cases [4] = '{{1'b0, 16'd1000}, {1'b1, 16'd2048},
                                          {1'b0, 16'd7}, {1'b1, 16'hFFFF}};
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (temp_valid === 1'b1) n_valid <= n_valid + 1;
   die_temp_indicator_ctrl dut (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .ref_settled, .analog_ctrl, .buf2_to_dac_cmp(b2d),
      .buf2_to_adc_channel(b2a), .buf1_to_adc_reference(b1r), .buf1_to_adc_channel(b1c),
      .count_valid, .sensor_adc_count, .calib, .temp_celsius, .temp_valid, .irq);
   die_temp_adc_model #(.CAL(CAL)) adc (.ref_clk, .analog_ctrl, .ref_settled, .count_valid,
      .sensor_adc_count, .calib);
   // ---------------
   // Access helpers
   // ---------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      #1;
   endtask : wr
   task automatic chk_rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask : chk_rd
   // Wide arithmetic keeps the product exact before the final 16-bit cut.
   function automatic logic [15:0] exp_temp(input logic [15:0] c, input logic hi);
      longint g, o;
      g = hi ? CAL.high_range_gain_const : CAL.low_range_gain_const;
      o = hi ? signed'(CAL.high_range_offset_const) : signed'(CAL.low_range_offset_const);
      return 16'((((longint'(c) * g) >>> 8) + o) / 10);
   endfunction : exp_temp
   task automatic convert(input logic [15:0] c, input logic hi);
      int w;
      wr(`OFS_REF_TEMP_CTRL, {3'b101, hi, 4'h0});
      adc.send_count(c);
      // The pulse is looked at between edges, where it has settled.
      w = 0;
      while (w < 40 && temp_valid !== 1'b1) begin
         @(negedge ref_clk);
         w++;
      end
      check(16'(w), 16'd27);
      check(temp_celsius, exp_temp(c, hi));
      chk_rd(`OFS_TEMP_RESULT, 8'(exp_temp(c, hi)));
   endtask : convert
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      give_verdict;
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      chk_rd(`OFS_REF_TEMP_CTRL, 8'h00);
      chk_rd(12'h100, 8'h00);
      wr(`OFS_REF_TEMP_CTRL, 8'hFF);
      chk_rd(`OFS_REF_TEMP_CTRL, 8'hBF);
      repeat (4) @(posedge ref_clk);
      chk_rd(`OFS_REF_TEMP_CTRL, 8'hFF);
      @(posedge ref_clk) clk_en <= 1'b0;
      wr(`OFS_REF_TEMP_CTRL, 8'h00);
      @(posedge ref_clk) clk_en <= 1'b1;
      chk_rd(`OFS_REF_TEMP_CTRL, 8'hFF);
      for (int g = 0; g < 4; g++) begin
         wr(`OFS_REF_TEMP_CTRL, {4'h8, 2'(3 - g), 2'(g)});
         check({b2d, b2a, b1r, b1c}, {{2{g != 3}}, {2{g != 0}}});
      end
      wr(`OFS_REF_TEMP_CTRL, 8'h0F);
      check({b2d, b2a, b1r, b1c}, 16'h0000);
      chk_rd(`OFS_REF_TEMP_CTRL, 8'h0F);
      wr(`OFS_TEMP_ENABLE, 8'h01);
      check(irq, 1'b0);
      chk_rd(`OFS_TEMP_ENABLE, 8'h01);
      foreach (cases[i]) convert(cases[i][15:0], cases[i][16]);
      avg_sum = 0;
      for (int k = 0; k < 10; k++) avg_sum += 1000 + 4 * k;
      convert(16'(avg_sum / 10), 1'b0);
      check(irq, 1'b1);
      chk_rd(`OFS_TEMP_STATUS, 8'h03);
      wr(`OFS_TEMP_ENABLE, 8'h00);
      check(irq, 1'b0);
      wr(`OFS_TEMP_CLEAR, 8'h03);
      wr(`OFS_TEMP_ENABLE, 8'h01);
      check(irq, 1'b0);
      wr(`OFS_REF_TEMP_CTRL, 8'h80);
      n_old = n_valid;
      adc.send_count(16'd50);
      repeat (40) @(posedge ref_clk);
      check(n_valid, n_old);
      give_verdict;
   end
endmodule : test_die_temp_indicator_ctrl
